// ==== bench/hifr_host_model.sv ====
// host processor model for the strobe bus
`timescale 1ns/1ps
`default_nettype none
module hifr_host_model (
  input wire logic clk_i,
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  input wire logic ack_oe_i,
  input wire logic irq_oe_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [13:0] addr_o,
  output logic [15:0] bus_o,
  output logic vack_n_o,
  output logic prio_n_o,
  output logic ack_o,
  output logic irq_o,
  output logic tmo_o
);
  logic [15:0] wd_q; // write data
  logic wen_q; // host drives the bus
  // ===========================================
  // line resolution: pull-ups when released
  assign ack_o = !ack_oe_i;
  assign irq_o = !irq_oe_i;
  assign bus_o = dq_oe_i ? dq_i : (wen_q ? wd_q : 16'hFFFF);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 14'h0000;
    wd_q = 16'h0000;
    wen_q = 1'b0;
    vack_n_o = 1'b1;
    prio_n_o = 1'b1;
    tmo_o = 1'b0;
  end
  task automatic wait_ack(input logic lvl);
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk_i);
      if (ack_o === lvl) break;
    end
    if (n == 100) tmo_o = 1'b1;
  endtask
  task automatic access(input logic [13:0] a, input logic wr,
                        input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_i);
    addr_o = a;
    wd_q = d;
    wen_q = wr;
    cs_n_o = 1'b0;
    rd_n_o = wr;
    wr_n_o = !wr;
    wait_ack(1'b0);
    q = bus_o;
    @(negedge clk_i);
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    wen_q = 1'b0;
    addr_o = ~a;
    wait_ack(1'b1);
  endtask
  // vector ack with cs high, rd low
  task automatic hw_ack(input logic p, output logic [15:0] v,
                        output logic seen);
    int n;
    v = 16'h0000;
    seen = 1'b0;
    @(negedge clk_i);
    prio_n_o = p;
    vack_n_o = 1'b0;
    rd_n_o = 1'b0;
    // whole window watched, so a refused ack shows nothing
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (dq_oe_i === 1'b1 && !seen) begin
        seen = 1'b1;
        v = bus_o;
      end
    end
    @(negedge clk_i);
    vack_n_o = 1'b1;
    rd_n_o = 1'b1;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // hifr_host_model
`default_nettype wire

// ==== bench/hifr_top_tb.sv ====
// self-checking bench for the host interrupt queue
`include "hifr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hifr_top_tb;
  logic clk, rst_n, mrst_n, ssel, sdsc, rev, tc6, cfg1, mrq, req;
  logic [15:0] hdr, dq, bus, v;
  logic dq_oe, ack_oe, irq_oe, pout, busy, smr, rdy, tmo, seen;
  logic cs_n, rd_n, wr_n, vack_n, prio_n, ack, irq, sm_seen;
  logic [13:0] addr;
  int mismatches, checks_done, i;
  logic [15:0] q[$]; // expected pop order
  hifr_top u_dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .master_rst_n_i(mrst_n),
    .chip_sel_n_i(cs_n), .host_rd_n_i(rd_n), .host_wr_lo_n_i(wr_n),
    .host_wr_hi_n_i(wr_n), .host_addr_i(addr), .host_data_bus_i(bus),
    .host_data_bus_o(dq), .host_data_bus_oe_o(dq_oe),
    .xfer_ack_n_o(), .xfer_ack_oe_o(ack_oe), .irq_n_o(),
    .irq_oe_o(irq_oe), .vector_ack_n_i(vack_n),
    .prio_chain_in_n_i(prio_n), .prio_chain_out_disconnect_o(pout),
    .store_mode_sel_i(ssel), .store_disconnected_i(sdsc),
    .revolve_mode_i(rev), .time_ctrl_bit6_i(tc6), .cfg1_bit1_i(cfg1),
    .mode_reset_i(mrq), .irq_req_i(req), .irq_header_i(hdr),
    .busy_o(busy), .sm_reset_o(smr), .ready_o(rdy));
  hifr_host_model u_h (
    .clk_i(clk), .dq_i(dq), .dq_oe_i(dq_oe), .ack_oe_i(ack_oe),
    .irq_oe_i(irq_oe), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n),
    .addr_o(addr), .bus_o(bus), .vack_n_o(vack_n), .prio_n_o(prio_n),
    .ack_o(ack), .irq_o(irq), .tmo_o(tmo));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // sticky catch of the one-cycle state-machine reset pulse
  always @(posedge clk) if (smr === 1'b1) sm_seen <= 1'b1;
  // ===========================================
  // checks and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (tmo === 1'b1) mismatches++;
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
    if (tmo === 1'b1) end_of_test();
  endtask
  task automatic push(input logic [15:0] h);
    @(negedge clk);
    req = 1'b1;
    hdr = h;
    @(negedge clk);
    req = 1'b0;
  endtask
  // pops via the pop address; last one carries the empty bit
  task automatic pop_all();
    logic [15:0] e;
    logic [15:0] d;
    while (q.size() > 0) begin
      e = q.pop_front();
      e[15] = (q.size() == 0);
      u_h.access(`HIFR_ADDR_POP, 1'b0, 16'h0000, d);
      chk(d, e);
    end
  endtask
  task automatic wait_rdy();
    // ready well inside the recovery time
    for (i = 0; i < `HIFR_RECOVER_NS / `HIFR_CLK_NS - 10 && rdy !== 1'b1;
         i++) @(posedge clk);
    chk({15'h0000, rdy}, 16'h0001);
    if (rdy !== 1'b1) end_of_test();
  endtask
  // ===========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    mrst_n = 1'b1;
    ssel = 1'b0;
    sdsc = 1'b0;
    rev = 1'b0;
    tc6 = 1'b0;
    cfg1 = 1'b0;
    mrq = 1'b0;
    req = 1'b0;
    hdr = 16'h0000;
    sm_seen = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    wait_rdy();
    chk({15'h0000, busy}, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    done("reset");
    for (i = 1; i < 4; i++) begin
      push(16'h0A10 + 16'(i));
      q.push_back(16'h0A10 + 16'(i));
    end
    repeat (4) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    pop_all();
    chk({15'h0000, irq}, 16'h0001);
    u_h.access(`HIFR_ADDR_VECTOR, 1'b0, 16'h0000, v);
    chk(v, 16'h8A13);
    u_h.access(`HIFR_ADDR_POP, 1'b0, 16'h0000, v);
    chk(v, 16'h8A13);
    done("soft pop");
    // seventh push overflows a six-deep queue
    for (i = 1; i < 8; i++) push(16'h0A20 + 16'(i));
    for (i = 3; i < 7; i++) q.push_back(16'h0A20 + 16'(i));
    q.push_back(`HIFR_OVF_VECTOR);
    q.push_back(16'h0A27);
    pop_all();
    done("overflow");
    @(negedge clk);
    rev = 1'b1;
    for (i = 1; i < 9; i++) push(16'h0A30 + 16'(i));
    for (i = 2; i < 9; i++) q.push_back(16'h0A30 + 16'(i));
    pop_all();
    @(negedge clk);
    rev = 1'b0;
    done("revolving");
    push(16'h0A41);
    push(16'h0B42);
    u_h.hw_ack(1'b1, v, seen);
    chk({15'h0000, seen}, 16'h0000);
    u_h.hw_ack(1'b0, v, seen);
    chk(v, 16'h4141);
    u_h.access(`HIFR_ADDR_VECTOR, 1'b0, 16'h0000, v);
    chk(v, 16'h0A41);
    chk({15'h0000, irq}, 16'h0000);
    u_h.hw_ack(1'b0, v, seen);
    chk(v, 16'h4242);
    chk({15'h0000, irq}, 16'h0001);
    done("hardware ack");
    chk({15'h0000, pout}, 16'h0000);
    push(16'h0A51);
    repeat (4) @(posedge clk);
    chk({15'h0000, pout}, 16'h0001);
    @(negedge clk);
    ssel = 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0000, pout}, 16'h0000);
    @(negedge clk);
    sdsc = 1'b1;
    repeat (4) @(posedge clk);
    chk({15'h0000, pout}, 16'h0001);
    done("priority out");
    // soft reset keeps the queue; busy held by control bit
    @(negedge clk);
    tc6 = 1'b1;
    cfg1 = 1'b1;
    // drop the pulse caught during power-up reset
    sm_seen = 1'b0;
    u_h.access(`HIFR_ADDR_SWRST, 1'b1, 16'h1234, v);
    chk({15'h0000, sm_seen}, 16'h0001);
    chk({15'h0000, busy}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    q.push_back(16'h0A51);
    pop_all();
    @(negedge clk);
    mrq = 1'b1;
    @(negedge clk);
    mrq = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    push(16'h0A61);
    @(negedge clk);
    mrst_n = 1'b0;
    repeat (40) @(negedge clk);
    mrst_n = 1'b1;
    // defaults suit this host, so no register rewrite
    repeat (4) @(posedge clk);
    chk({15'h0000, rdy}, 16'h0000);
    wait_rdy();
    chk({15'h0000, irq}, 16'h0001);
    done("resets");
    end_of_test();
  end
endmodule // hifr_top_tb
`default_nettype wire

// ==== verilog/hifr_consts.svh ====
// constants for the host interrupt queue and reset port
`ifndef HIFR_CONSTS_SVH
`define HIFR_CONSTS_SVH
// register word addresses on the host address bus
`define HIFR_ADDR_VECTOR 14'h0004
`define HIFR_ADDR_POP 14'h0008
`define HIFR_ADDR_SWRST 14'h000F
// fifo depths per mode
`define HIFR_DEPTH_NORMAL 3'h6
`define HIFR_DEPTH_REVOLVE 3'h7
// overflow marker, distinct from any header
`define HIFR_OVF_VECTOR 16'hFFFF
// auxiliary vector empty indication bit
`define HIFR_AUX_EMPTY_BIT 8
// control bit positions
`define HIFR_TIME_CTRL_BIT 6
`define HIFR_CFG1_BIT 1
// recovery time and clock
`define HIFR_RECOVER_NS 12000
`define HIFR_CLK_NS 10
`endif

// ==== verilog/hifr_pkg.sv ====
// types for the host interrupt queue and reset port
`default_nettype none
package hifr_pkg;
  // host access sequencer states, gray from idle through busy to done; done back to idle flips both bits
  typedef enum logic [1:0] {
    HIFR_IDLE = 2'b00,
    HIFR_BUSY = 2'b01,
    HIFR_DONE = 2'b11
  } hifr_state_e;
endpackage
`default_nettype wire

// ==== verilog/hifr_top.sv ====
// host interrupt fifo, acknowledge and reset port
// ======================================================
`include "hifr_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hifr_top #(
  parameter int HW = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic master_rst_n_i,
  input wire logic chip_sel_n_i,
  input wire logic host_rd_n_i,
  input wire logic host_wr_lo_n_i,
  input wire logic host_wr_hi_n_i,
  input wire logic [13:0] host_addr_i,
  input wire logic [15:0] host_data_bus_i,
  output logic [15:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  output logic xfer_ack_n_o,
  output logic xfer_ack_oe_o,
  output logic irq_n_o,
  output logic irq_oe_o,
  input wire logic vector_ack_n_i,
  input wire logic prio_chain_in_n_i,
  output logic prio_chain_out_disconnect_o,
  input wire logic store_mode_sel_i,
  input wire logic store_disconnected_i,
  input wire logic revolve_mode_i,
  input wire logic time_ctrl_bit6_i,
  input wire logic cfg1_bit1_i,
  input wire logic mode_reset_i,
  input wire logic irq_req_i,
  input wire logic [HW-1:0] irq_header_i,
  output logic busy_o,
  output logic sm_reset_o,
  output logic ready_o
);
  // ======================================================
  // reset release and pin synchronisers
  // ======================================================
  localparam int REC_CYC = `HIFR_RECOVER_NS / `HIFR_CLK_NS;
  logic [1:0] rst_sync_q;
  logic rst_n;
  // reset released through two flops
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];
  // assertions below share this clock and the internal reset
  default clocking cb_a @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);
  // async host pins: cs, rd, wrl, wrh, ack, prio, mrst
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 7'h7F;
      pin_s2_q <= 7'h7F;
    end else begin
      pin_s1_q <= {master_rst_n_i, prio_chain_in_n_i, vector_ack_n_i,
                   host_wr_hi_n_i, host_wr_lo_n_i, host_rd_n_i,
                   chip_sel_n_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic cs_n, rd_n, wrl_n, wrh_n, ack_n, prio_n, mrst_n;
  assign {mrst_n, prio_n, ack_n, wrh_n, wrl_n, rd_n, cs_n} = pin_s2_q;
  logic cs_n_q;
  // edge history of synchronised chip select
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_q <= 1'b1;
    end else begin
      cs_n_q <= cs_n;
    end
  end
  // ======================================================
  // host access sequencer
  // ======================================================
  hifr_pkg::hifr_state_e st_q;
  logic [13:0] addr_q;
  logic is_rd_q, is_hack_q;
  logic hard_rst, soft_rst, pop, start_cs, start_hack, enter_done;
  // hardware reset pin low, caught synchronously
  assign hard_rst = !mrst_n;
  assign start_cs = cs_n_q && !cs_n && (st_q == hifr_pkg::HIFR_IDLE);
  // acknowledge needs cs high, prio low
  assign start_hack = cs_n && !ack_n && !rd_n && !prio_n &&
                      (st_q == hifr_pkg::HIFR_IDLE);
  // sequencer: idle, busy until a strobe, done until cs or the ack strobes release
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= hifr_pkg::HIFR_IDLE;
      addr_q <= 14'h0000;
      is_rd_q <= 1'b0;
      is_hack_q <= 1'b0;
    end else if (hard_rst) begin
      st_q <= hifr_pkg::HIFR_IDLE;
    end else begin
      case (st_q)
        hifr_pkg::HIFR_IDLE: begin
          if (start_cs) begin
            // address latched at the falling edge
            addr_q <= host_addr_i;
            is_rd_q <= 1'b0;
            is_hack_q <= 1'b0;
            st_q <= hifr_pkg::HIFR_BUSY;
          end else if (start_hack) begin
            is_hack_q <= 1'b1;
            is_rd_q <= 1'b1;
            st_q <= hifr_pkg::HIFR_BUSY;
          end
        end
        hifr_pkg::HIFR_BUSY: begin
          // wait for a strobe, or cs end aborts
          if (is_hack_q || !rd_n) begin
            is_rd_q <= 1'b1;
            st_q <= hifr_pkg::HIFR_DONE;
          end else if (!wrl_n || !wrh_n) begin
            st_q <= hifr_pkg::HIFR_DONE;
          end else if (cs_n) begin
            st_q <= hifr_pkg::HIFR_IDLE;
          end
        end
        hifr_pkg::HIFR_DONE: begin
          if (is_hack_q ? (ack_n || rd_n) : cs_n) begin
            st_q <= hifr_pkg::HIFR_IDLE;
          end
        end
        default: st_q <= hifr_pkg::HIFR_IDLE;
      endcase
    end
  end
  assign enter_done = (st_q == hifr_pkg::HIFR_BUSY) &&
                      (is_hack_q || !rd_n || !wrl_n || !wrh_n);
  // read of address eight pops; hw ack pops
  assign pop = enter_done && (is_hack_q || (!rd_n &&
               addr_q == `HIFR_ADDR_POP));
  // write of any data to fifteen
  assign soft_rst = enter_done && !is_hack_q && rd_n &&
                    addr_q == `HIFR_ADDR_SWRST;
  // ======================================================
  // interrupt header fifo
  // ======================================================
  logic [HW-1:0] mem_q [0:6];
  logic [2:0] cnt_q;
  logic [2:0] lim;
  assign lim = revolve_mode_i ? `HIFR_DEPTH_REVOLVE : `HIFR_DEPTH_NORMAL;
  logic [HW-1:0] prim_q, aux_q;
  // entries survive soft and mode resets; only master and power-up resets empty
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      for (int i = 0; i < 7; i++) begin
        mem_q[i] <= '0;
      end
    end else if (hard_rst) begin
      cnt_q <= 3'h0;
    end else begin
      if (irq_req_i && cnt_q >= lim && !revolve_mode_i) begin
        // drop two oldest, push marker then header
        for (int i = 0; i < 4; i++) begin
          mem_q[i] <= mem_q[i+2];
        end
        mem_q[4] <= HW'(`HIFR_OVF_VECTOR);
        mem_q[5] <= irq_header_i;
      end else if (irq_req_i && cnt_q >= lim) begin
        for (int i = 0; i < 6; i++) begin
          mem_q[i] <= mem_q[i+1];
        end
        mem_q[6] <= irq_header_i;
      end else if (irq_req_i && pop && cnt_q != 3'h0) begin
        // push and pop together keep the count
        for (int i = 0; i < 6; i++) begin
          mem_q[i] <= mem_q[i+1];
        end
        mem_q[cnt_q-3'h1] <= irq_header_i;
      end else if (irq_req_i) begin
        mem_q[cnt_q] <= irq_header_i;
        cnt_q <= cnt_q + 3'h1;
      end else if (pop && cnt_q != 3'h0) begin
        for (int i = 0; i < 6; i++) begin
          mem_q[i] <= mem_q[i+1];
        end
        cnt_q <= cnt_q - 3'h1;
      end
    end
  end
  // ======================================================
  // vector registers
  // ======================================================
  // popped entry held for address four reads
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prim_q <= '0;
      aux_q <= '0;
    end else if (hard_rst) begin
      prim_q <= '0;
      aux_q <= '0;
    end else if (pop) begin
      prim_q <= (cnt_q != 3'h0) ? mem_q[0] : prim_q;
      aux_q <= '0;
      aux_q[`HIFR_AUX_EMPTY_BIT] <= (cnt_q <= 3'h1) && !irq_req_i;
    end
  end
  // ======================================================
  // host data bus and handshake
  // ======================================================
  logic [15:0] rdata;
  always_comb begin
    rdata = 16'h0000;
    if (is_hack_q) begin
      rdata = {prim_q[7:0], prim_q[7:0]};
    end else if (addr_q == `HIFR_ADDR_VECTOR ||
                 addr_q == `HIFR_ADDR_POP) begin
      rdata = {aux_q[`HIFR_AUX_EMPTY_BIT], prim_q[14:0]};
    end
  end
  // drive data and ack only in done state
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      host_data_bus_o <= 16'h0000;
      host_data_bus_oe_o <= 1'b0;
      xfer_ack_oe_o <= 1'b0;
    end else begin
      host_data_bus_o <= rdata;
      host_data_bus_oe_o <= (st_q == hifr_pkg::HIFR_DONE) && is_rd_q;
      // ack once data stable or write done
      xfer_ack_oe_o <= (st_q == hifr_pkg::HIFR_DONE) && !is_hack_q;
    end
  end
  // open drain pins only pull low
  assign xfer_ack_n_o = 1'b0;
  assign irq_n_o = 1'b0;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_oe_o <= 1'b0;
    end else begin
      irq_oe_o <= (cnt_q != 3'h0) || irq_req_i;
    end
  end
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prio_chain_out_disconnect_o <= 1'b1;
    end else if (store_mode_sel_i) begin
      prio_chain_out_disconnect_o <= store_disconnected_i;
    end else begin
      prio_chain_out_disconnect_o <= (cnt_q != 3'h0) || prio_n;
    end
  end
  // ======================================================
  // reset handling and busy
  // ======================================================
  logic [10:0] rec_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      busy_o <= 1'b1;
    end else if (hard_rst || mode_reset_i) begin
      busy_o <= 1'b1;
    end else if (soft_rst && !time_ctrl_bit6_i && !cfg1_bit1_i) begin
      busy_o <= 1'b1;
    end
  end
  // state machine reset pulse; soft and mode resets leave memory untouched, master reset empties the queue
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sm_reset_o <= 1'b1;
    end else begin
      sm_reset_o <= hard_rst || soft_rst || mode_reset_i;
    end
  end
  // recovery counted from reset release, under 12us
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rec_q <= 11'h000;
      ready_o <= 1'b0;
    end else if (hard_rst) begin
      rec_q <= 11'h000;
      ready_o <= 1'b0;
    end else if (rec_q < 11'(REC_CYC / 2)) begin
      rec_q <= rec_q + 11'h001;
    end else begin
      ready_o <= 1'b1;
    end
  end
  // ======================================================
  // assertions
  // ======================================================
  a_irq_follows_q: assert property ((cnt_q != 3'h0) |=> irq_oe_o)
    else $error("irq released with queue nonempty");
  a_depth_normal_max: assert property (
    !revolve_mode_i |-> cnt_q <= `HIFR_DEPTH_NORMAL)
    else $error("normal depth exceeded");
  a_ovf_marker_push: assert property (
    irq_req_i && !revolve_mode_i && cnt_q == `HIFR_DEPTH_NORMAL && !hard_rst
    |=> mem_q[4] == HW'(`HIFR_OVF_VECTOR))
    else $error("overflow marker missing");
  a_prio_blocks_ack: assert property (
    prio_n && cs_n && st_q == hifr_pkg::HIFR_IDLE
    |=> !is_hack_q || $stable(is_hack_q))
    else $error("ack taken with priority high");
  a_soft_busy_hold: assert property (
    soft_rst && (time_ctrl_bit6_i || cfg1_bit1_i) && !hard_rst &&
    !mode_reset_i |=> $stable(busy_o))
    else $error("soft reset set busy");
  a_hard_busy_set: assert property (
    (hard_rst || mode_reset_i) |=> busy_o)
    else $error("busy not set");
  a_empty_aux_bit: assert property (
    pop && cnt_q == 3'h1 && !irq_req_i && !hard_rst
    |=> aux_q[`HIFR_AUX_EMPTY_BIT] ##1 (!irq_oe_o || $past(irq_req_i)))
    else $error("empty bit not set");
  a_ack_after_done: assert property (
    st_q == hifr_pkg::HIFR_DONE && !is_hack_q |=> xfer_ack_oe_o)
    else $error("transfer ack missing");
  c_overflow: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    irq_req_i && cnt_q == 3'h6 && !revolve_mode_i);
  c_hw_ack: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    pop && is_hack_q);
  c_sw_pop: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    pop && !is_hack_q);
  c_soft_rst: cover property (@(posedge ref_clk_i) disable iff (!rst_n)
    soft_rst);
endmodule // hifr_top
`default_nettype wire
